// [core/eab_consts.svh]
// offsets, field positions, reset values and counts of the area controller
`ifndef EAB_CONSTS_SVH
`define EAB_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define EAB_OFF_ABW      24'hFFFEC0
`define EAB_OFF_AST      24'hFFFEC1
`define EAB_OFF_WAH      24'hFFFEC2
`define EAB_OFF_WAL      24'hFFFEC3
`define EAB_OFF_WBH      24'hFFFEC4
`define EAB_OFF_WBL      24'hFFFEC5
`define EAB_OFF_RDN      24'hFFFEC6
`define EAB_OFF_LEAD     24'hFFFEC8
`define EAB_OFF_TRAIL    24'hFFFEC9
`define EAB_OFF_BROM0    24'hFFFECA
`define EAB_OFF_BROM1    24'hFFFECB
`define EAB_OFF_PFC      24'hFFFEB0
`define EAB_OFF_STAT     24'hFFFEB1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EAB_RST_ABW_BOOT  8'h81
`define EAB_RST_ABW_NORM  8'h80
`define EAB_RST_AST       8'hFF
`define EAB_RST_WAH       8'h27
`define EAB_RST_WAL       8'h77
`define EAB_RST_WBH       8'h71
`define EAB_RST_WBL_BOOT  8'h23
`define EAB_RST_WBL_NORM  8'h22
`define EAB_RST_RDN       8'h00
`define EAB_RST_LEAD      8'h80
`define EAB_RST_TRAIL     8'h80
`define EAB_RST_BR0_BOOT  8'hD3
`define EAB_RST_BR0_NORM  8'hA3
`define EAB_RST_BROM1     8'hA3
`define EAB_RST_PFC       8'h00

// ----------------------------------------------------------------------
// writable bit masks and field positions
// ----------------------------------------------------------------------
`define EAB_MASK_WAIT     8'h77
`define EAB_MASK_BROM     8'hF3
`define EAB_BROM_EN       7
`define EAB_BROM_BST_LSB  4
`define EAB_BROM_BSW_LSB  0

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define EAB_AREA_LSB      21
`define EAB_LAN_TAG       6'h3E
`define EAB_BFL_TAG       4'hE
`define EAB_BFL_BITS      19
`define EAB_LAN_BITS      4
`define EAB_IRAM_LO       24'hFF4000
`define EAB_IRAM_HI       24'hFFBFFF
`define EAB_IO0_LO        24'hFFFC00
`define EAB_IO0_HI        24'hFFFEFF
`define EAB_IO1_LO        24'hFFFF20
`define EAB_SDR_FIRST     3'h2
`define EAB_SDR_LAST      3'h5

// ----------------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------------
`define EAB_BASE_STATES   8'h02
`define EAB_BURST_BASE    6'h04
`define EAB_INIT_DONE     2'h3
`define EAB_INIT_LOAD     2'h2

`endif

// [core/eab_pkg.sv]
// types shared by the area controller modules
package eab_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_STROBE,
    ST_TRAIL
  } eab_state_t;

  typedef struct packed {
    logic [1:0]  init_cnt;
    logic        boot;
    logic [7:0]  area_width_bit;
    logic [7:0]  ast;
    logic [31:0] wtcr;
    logic [7:0]  read_strobe_early_bit;
    logic [7:0]  lead;
    logic [7:0]  trail;
    logic [7:0]  brom0;
    logic [7:0]  brom1;
    logic [7:0]  pfc;
    eab_state_t  state;
    logic [7:0]  cnt;
    logic        is_rd;
    logic        do_trail;
    logic        early;
    logic [7:0]  cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        bus16;
    logic        done;
    logic        busy;
    logic        lan;
    logic        page;
    logic [23:0] addr;
    logic [7:0]  rdata;
  } eab_regs_t;

endpackage : eab_pkg

// [core/eab_sync.sv]
// two-stage synchroniser for pin levels
`timescale 1ns/1ns
module eab_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } eab_sync_t;

  eab_sync_t r;
  eab_sync_t next_r;

  always_comb begin
    next_r.meta   = i_d;
    next_r.stable = r.meta;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_q = r.stable;

endmodule : eab_sync

// [core/eab_decode.sv]
// address decoder: area, internal ranges and device address translation
`timescale 1ns/1ns
module eab_decode (
  input  wire logic [23:0] i_addr,
  input  wire logic        i_boot,
  input  wire logic        i_iram_en,
  input  wire logic        i_page,
  output logic      [2:0]  o_area,
  output logic             o_ext,
  output logic             o_lan,
  output logic             o_sdram,
  output logic             o_page,
  output logic      [23:0] o_mem_addr
);
  `include "eab_consts.svh"

  logic iram_hit;
  logic io_hit;
  logic bfl_hit;

  always_comb begin
    o_area   = i_addr[23:`EAB_AREA_LSB];
    iram_hit = i_iram_en && (i_addr >= `EAB_IRAM_LO)
               && (i_addr <= `EAB_IRAM_HI);
    io_hit   = ((i_addr >= `EAB_IO0_LO) && (i_addr <= `EAB_IO0_HI))
               || (i_addr >= `EAB_IO1_LO);
    o_ext    = !(iram_hit || io_hit);
    o_lan    = (i_addr[23:18] == `EAB_LAN_TAG);
    o_sdram  = (o_area >= `EAB_SDR_FIRST) && (o_area <= `EAB_SDR_LAST);
    bfl_hit  = (i_boot && (o_area == 3'h0))
               || (i_addr[23:20] == `EAB_BFL_TAG);
    o_page   = i_boot ? i_page : (o_area == 3'h1);
    if (bfl_hit) begin
      o_mem_addr = {5'h00, i_addr[`EAB_BFL_BITS-1:0]};
    end else if (o_lan) begin
      o_mem_addr = {20'h00000, i_addr[`EAB_LAN_BITS-1:0]};
    end else begin
      o_mem_addr = i_addr;
    end
  end

endmodule : eab_decode

// [core/eab_ctrl.sv]
// external area bus controller: registers, chip selects and access timing
//
// Notes on behaviour
// - eight 2 Mbyte areas, each with its own active-low select line.
// - a select pin is driven only when its pin function bit is set.
// - normal mode: flash page 0 in area 0, page 1 in area 1.
// - boot mode: boot flash image repeats in area 0; in both modes it also repeats at E00000 to EFFFFF in area 7.
// - SDRAM in areas 2 to 5, always 16 bits wide.
// - LAN window at F80000, 256KB, 16-byte set repeating.
// - FF4000 to FFBFFF is internal RAM only while it is enabled.
// - boot: areas 0 and 7 are 8 bits; normal: only area 7.
// - width bits start as boot or normal values from the mode strap.
// - all eight areas use three-state access cycles after reset.
// - area 7 inserts 2 program wait states.
// - area 6 inserts 7 program wait states.
// - area 1 waits 2; area 0 waits 3 in boot, 2 in normal.
// - SDRAM wait field sets column latency, 2 cycles after reset in area 2, 8 in areas 3 to 5.
// - read strobe negates at cycle end unless early bit set.
// - area 7 basic accesses extend select before and after strobe.
// - area 0 burst ROM, 4 words, 6 states boot, 3 normal.
// - area 1 burst ROM, 4 words, 3-state bursts in both modes.
`timescale 1ns/1ns
module eab_ctrl (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_ARST_N,
  input  wire logic [23:0] I_REG_ADDR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic      [7:0]  O_REG_RDATA,
  input  wire logic        I_BOOT_STRAP,
  input  wire logic        I_PAGE_PIN,
  input  wire logic        I_INT_RAM_EN,
  input  wire logic        I_ACC_REQ,
  input  wire logic [23:0] I_ACC_ADDR,
  input  wire logic        I_ACC_RD,
  input  wire logic [2:0]  I_ACC_LEN,
  output logic             O_ACC_BUSY,
  output logic             O_ACC_DONE,
  output logic      [7:0]  O_CS_N,
  output logic      [7:0]  O_CS_OE,
  output logic             O_RD_N,
  output logic             O_WR_N,
  output logic      [23:0] O_MEM_ADDR,
  output logic             O_BUS16,
  output logic             O_LAN_SEL,
  output logic             O_MAIN_PAGE,
  output logic             O_BOOT_MODE
);
  import eab_pkg::*;
  `include "eab_consts.svh"

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] pins_sync;

  eab_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .i_clk    (I_CLK_SYS),
    .i_arst_n (I_ARST_N),
    .i_d      ({I_BOOT_STRAP, I_PAGE_PIN}),
    .o_q      (pins_sync)
  );

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  eab_regs_t   r;
  eab_regs_t   next_r;
  logic [2:0]  dec_area;
  logic        dec_ext;
  logic        dec_lan;
  logic        dec_sdram;
  logic        dec_page;
  logic [23:0] dec_mem_addr;

  eab_decode u_decode (
    .i_addr     (I_ACC_ADDR),
    .i_boot     (r.boot),
    .i_iram_en  (I_INT_RAM_EN),
    .i_page     (pins_sync[0]),
    .o_area     (dec_area),
    .o_ext      (dec_ext),
    .o_lan      (dec_lan),
    .o_sdram    (dec_sdram),
    .o_page     (dec_page),
    .o_mem_addr (dec_mem_addr)
  );

  // ----------------------------------------------------------------------
  // access timing for the addressed area
  // ----------------------------------------------------------------------
  logic [2:0] wfld;
  logic       ast_b;
  logic [7:0] brom;
  logic       burst;
  logic [7:0] bst;
  logic [7:0] limit;
  logic [7:0] req_words;
  logic [7:0] words;
  logic [7:0] first;
  logic [7:0] total;
  logic [7:0] sel;

  always_comb begin
    wfld  = r.wtcr[{dec_area, 2'b00} +: 3];
    ast_b = r.ast[dec_area];
    brom  = (dec_area == 3'h0) ? r.brom0 : r.brom1;
    // bursts only for reads from areas 0 and 1
    burst = I_ACC_RD && (dec_area[2:1] == 2'b00)
            && brom[`EAB_BROM_EN];
    bst   = {5'h00, brom[`EAB_BROM_BST_LSB +: 3]} + 8'h01;
    // an all-ones word field gives the base limit of four words
    limit = {2'b00, `EAB_BURST_BASE
             << ~brom[`EAB_BROM_BSW_LSB +: 2]};
    req_words = {5'h00, I_ACC_LEN} + 8'h01;
    if (!burst) begin
      words = 8'h01;
    end else if (req_words > limit) begin
      words = limit;
    end else begin
      words = req_words;
    end
    first = `EAB_BASE_STATES;
    if (dec_sdram) begin
      // wait field is the column latency here
      first = first + {7'h00, ast_b} + {5'h00, wfld}
              + 8'h01;
    end else if (ast_b) begin
      first = first + 8'h01 + {5'h00, wfld};
    end
    total = first + 8'((words - 8'h01) * bst);
    sel   = ~(8'h01 << dec_area);
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic cfg_open;
  logic take;

  always_comb begin
    next_r       = r;
    next_r.done  = 1'b0;
    next_r.rdata = 8'h00;
    cfg_open     = (r.init_cnt == `EAB_INIT_DONE);
    take         = 1'b0;

    // mode strap captured once the synchroniser has settled
    if (r.init_cnt == `EAB_INIT_LOAD) begin
      next_r.boot = pins_sync[1];
      if (pins_sync[1]) begin
        next_r.area_width_bit        = `EAB_RST_ABW_BOOT;
        next_r.wtcr[7:0]  = `EAB_RST_WBL_BOOT;
        next_r.brom0      = `EAB_RST_BR0_BOOT;
      end else begin
        next_r.area_width_bit        = `EAB_RST_ABW_NORM;
        next_r.wtcr[7:0]  = `EAB_RST_WBL_NORM;
        next_r.brom0      = `EAB_RST_BR0_NORM;
      end
    end
    if (!cfg_open) begin
      next_r.init_cnt = r.init_cnt + 2'h1;
    end

    // register writes
    if (cfg_open && I_REG_WR) begin
      unique case (I_REG_ADDR)
        `EAB_OFF_ABW:   next_r.area_width_bit   = I_REG_WDATA;
        `EAB_OFF_AST:   next_r.ast   = I_REG_WDATA;
        `EAB_OFF_WAH:   next_r.wtcr[31:24] = I_REG_WDATA & `EAB_MASK_WAIT;
        `EAB_OFF_WAL:   next_r.wtcr[23:16] = I_REG_WDATA & `EAB_MASK_WAIT;
        `EAB_OFF_WBH:   next_r.wtcr[15:8]  = I_REG_WDATA & `EAB_MASK_WAIT;
        `EAB_OFF_WBL:   next_r.wtcr[7:0]   = I_REG_WDATA & `EAB_MASK_WAIT;
        `EAB_OFF_RDN:   next_r.read_strobe_early_bit   = I_REG_WDATA;
        `EAB_OFF_LEAD:  next_r.lead  = I_REG_WDATA;
        `EAB_OFF_TRAIL: next_r.trail = I_REG_WDATA;
        `EAB_OFF_BROM0: next_r.brom0 = I_REG_WDATA & `EAB_MASK_BROM;
        `EAB_OFF_BROM1: next_r.brom1 = I_REG_WDATA & `EAB_MASK_BROM;
        `EAB_OFF_PFC:   next_r.pfc   = I_REG_WDATA;
        default: ;
      endcase
    end

    // register reads, data stands for one cycle
    if (I_REG_RD) begin
      unique case (I_REG_ADDR)
        `EAB_OFF_ABW:   next_r.rdata = r.area_width_bit;
        `EAB_OFF_AST:   next_r.rdata = r.ast;
        `EAB_OFF_WAH:   next_r.rdata = r.wtcr[31:24];
        `EAB_OFF_WAL:   next_r.rdata = r.wtcr[23:16];
        `EAB_OFF_WBH:   next_r.rdata = r.wtcr[15:8];
        `EAB_OFF_WBL:   next_r.rdata = r.wtcr[7:0];
        `EAB_OFF_RDN:   next_r.rdata = r.read_strobe_early_bit;
        `EAB_OFF_LEAD:  next_r.rdata = r.lead;
        `EAB_OFF_TRAIL: next_r.rdata = r.trail;
        `EAB_OFF_BROM0: next_r.rdata = r.brom0;
        `EAB_OFF_BROM1: next_r.rdata = r.brom1;
        `EAB_OFF_PFC:   next_r.rdata = r.pfc;
        `EAB_OFF_STAT:  next_r.rdata = {cfg_open, r.boot, r.busy,
                                        r.page, r.lan, r.cs_n == 8'hFF,
                                        r.state};
        default:        next_r.rdata = 8'h00;
      endcase
    end

    // access sequencer
    unique case (r.state)
      ST_IDLE: begin
        take = cfg_open && I_ACC_REQ;
        if (take && !dec_ext) begin
          // internal range: no select, answered at once
          next_r.done = 1'b1;
        end else if (take) begin
          next_r.busy     = 1'b1;
          next_r.is_rd    = I_ACC_RD;
          next_r.addr     = dec_mem_addr;
          next_r.lan      = dec_lan;
          next_r.page     = dec_page;
          next_r.bus16    = dec_sdram
                            || !r.area_width_bit[dec_area];
          next_r.early    = I_ACC_RD && r.read_strobe_early_bit[dec_area];
          next_r.do_trail = !burst && r.trail[dec_area];
          next_r.cnt      = total - 8'h01;
          next_r.cs_n     = sel;
          if (!burst && r.lead[dec_area]) begin
            next_r.state = ST_LEAD;
          end else begin
            next_r.state = ST_STROBE;
            next_r.rd_n  = !I_ACC_RD;
            next_r.wr_n  = I_ACC_RD;
          end
        end
      end
      ST_LEAD: begin
        next_r.state = ST_STROBE;
        next_r.rd_n  = !r.is_rd;
        next_r.wr_n  = r.is_rd;
      end
      ST_STROBE: begin
        if (r.cnt == 8'h00) begin
          next_r.rd_n = 1'b1;
          next_r.wr_n = 1'b1;
          if (r.do_trail) begin
            next_r.state = ST_TRAIL;
          end else begin
            next_r.state = ST_IDLE;
            next_r.cs_n  = 8'hFF;
            next_r.done  = 1'b1;
            next_r.busy  = 1'b0;
          end
        end else begin
          next_r.cnt = r.cnt - 8'h01;
          if (r.early && (r.cnt == 8'h01)) begin
            next_r.rd_n = 1'b1;
          end
        end
      end
      ST_TRAIL: begin
        next_r.state = ST_IDLE;
        next_r.cs_n  = 8'hFF;
        next_r.done  = 1'b1;
        next_r.busy  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      r          <= '0;
      r.area_width_bit      <= `EAB_RST_ABW_NORM;
      r.ast      <= `EAB_RST_AST;
      r.wtcr     <= {`EAB_RST_WAH, `EAB_RST_WAL, `EAB_RST_WBH,
                     `EAB_RST_WBL_NORM};
      r.read_strobe_early_bit      <= `EAB_RST_RDN;
      r.lead     <= `EAB_RST_LEAD;
      r.trail    <= `EAB_RST_TRAIL;
      r.brom0    <= `EAB_RST_BR0_NORM;
      r.brom1    <= `EAB_RST_BROM1;
      r.pfc      <= `EAB_RST_PFC;
      r.state    <= ST_IDLE;
      r.cs_n     <= 8'hFF;
      r.rd_n     <= 1'b1;
      r.wr_n     <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign O_REG_RDATA = r.rdata;
  assign O_ACC_BUSY  = r.busy;
  assign O_ACC_DONE  = r.done;
  assign O_CS_N      = r.cs_n;
  assign O_CS_OE     = r.pfc;
  assign O_RD_N      = r.rd_n;
  assign O_WR_N      = r.wr_n;
  assign O_MEM_ADDR  = r.addr;
  assign O_BUS16     = r.bus16;
  assign O_LAN_SEL   = r.lan;
  assign O_MAIN_PAGE = r.page;
  assign O_BOOT_MODE = r.boot;

endmodule : eab_ctrl

// [dv/eab_ctrl_checker.sv]
// port assertions of the area bus controller
`timescale 1ns/1ns
module eab_ctrl_checker (
  input wire logic        I_CLK_SYS,
  input wire logic        I_ARST_N,
  input wire logic [23:0] I_REG_ADDR,
  input wire logic        I_REG_WR,
  input wire logic [23:0] I_ACC_ADDR,
  input wire logic        O_ACC_BUSY,
  input wire logic        O_ACC_DONE,
  input wire logic [7:0]  O_CS_N,
  input wire logic [7:0]  O_CS_OE,
  input wire logic        O_RD_N,
  input wire logic        O_WR_N,
  input wire logic        O_BUS16,
  input wire logic        O_BOOT_MODE
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);

  sequence s_rd_hold4;
    ##1 !O_RD_N [*4] ##1 O_RD_N;
  endsequence

  sequence s_wr_hold10;
    ##1 !O_WR_N [*8] ##1 !O_WR_N ##1 O_WR_N;
  endsequence

  a_cs_one_hot: assert property (
    $countones(~O_CS_N) <= 1) else $error("two area selects low");
  a_cs_area_match: assert property (
    $rose(O_ACC_BUSY) |-> O_CS_N == ~(8'h01 << ($past(I_ACC_ADDR) >> 21)))
    else $error("select does not match area");
  a_oe_by_write: assert property (
    $changed(O_CS_OE) |-> $past(I_REG_WR) && $past(I_REG_ADDR) == 24'hFFFEB0)
    else $error("select enable changed without write");
  a_area7_lead: assert property (
    $rose(O_ACC_BUSY) && !O_CS_N[7] |-> (O_RD_N && O_WR_N)
      ##1 !(O_RD_N && O_WR_N)) else $error("no lead cycle in area 7");
  a_area7_wait: assert property (
    $fell(O_RD_N) && !O_CS_N[7] |-> s_rd_hold4)
    else $error("area 7 strobe length wrong");
  a_area7_trail: assert property (
    $rose(O_RD_N) && !O_CS_N[7] |=> O_CS_N == 8'hFF && O_ACC_DONE)
    else $error("no trail cycle in area 7");
  a_area6_wait: assert property (
    $fell(O_WR_N) && !O_CS_N[6] |-> s_wr_hold10)
    else $error("area 6 strobe length wrong");
  a_sdram_latency: assert property (
    $fell(O_RD_N) && !O_CS_N[2] |-> s_rd_hold4)
    else $error("sdram strobe length wrong");
  a_sdram_width: assert property (
    $rose(O_ACC_BUSY) && O_CS_N[5:2] != 4'hF |-> O_BUS16)
    else $error("sdram not 16 bit");
  a_area_width: assert property (
    $rose(O_ACC_BUSY) && !(O_CS_N[7] && O_CS_N[0])
      |-> O_BUS16 == (!O_CS_N[0] && !O_BOOT_MODE))
    else $error("area 0 or 7 width wrong");
endmodule : eab_ctrl_checker

bind eab_ctrl eab_ctrl_checker eab_ctrl_checker_inst (
  .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_REG_ADDR(I_REG_ADDR),
  .I_REG_WR(I_REG_WR), .I_ACC_ADDR(I_ACC_ADDR), .O_ACC_BUSY(O_ACC_BUSY),
  .O_ACC_DONE(O_ACC_DONE), .O_CS_N(O_CS_N), .O_CS_OE(O_CS_OE),
  .O_RD_N(O_RD_N), .O_WR_N(O_WR_N), .O_BUS16(O_BUS16),
  .O_BOOT_MODE(O_BOOT_MODE));

// [dv/eab_mem_model.sv]
// far-side model: page pin and strobe length of each external access
`timescale 1ns/1ns
module eab_mem_model (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic [7:0] i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_page_sel,
  output logic            o_page_pin,
  output logic            o_vld,
  output logic      [7:0] o_cs,
  output logic      [7:0] o_len
);
  // ----------------------------------------------------------------
  // page pin and access recorder
  // ----------------------------------------------------------------
  logic [7:0] cnt;
  logic [7:0] cs_seen;
  logic       act;

  // software level on the page port pin
  assign o_page_pin = i_page_sel;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt     <= 8'h00;
      cs_seen <= 8'hFF;
      act     <= 1'b0;
      o_vld   <= 1'b0;
      o_cs    <= 8'hFF;
      o_len   <= 8'h00;
    end else begin
      act   <= (i_cs_n != 8'hFF);
      o_vld <= act && (i_cs_n == 8'hFF);
      if (i_cs_n != 8'hFF) begin
        cs_seen <= i_cs_n;
        cnt     <= cnt + {7'h00, !(i_rd_n && i_wr_n)};
      end else if (act) begin
        o_cs  <= cs_seen;
        o_len <= cnt;
        cnt   <= 8'h00;
      end
    end
  end
endmodule : eab_mem_model

// [dv/tb.sv]
// self-checking bench of the area bus controller
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // signals and tables
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] a;
    logic        r;
    logic [2:0]  n;
    logic [7:0]  s;
  } eab_acc_t;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, req = 1'b0, ard = 1'b0, rd_d = 1'b0;
  logic        strap = 1'b0, pg = 1'b0, iram = 1'b0;
  logic [23:0] ra = 24'h000000, aa = 24'h000000;
  logic [7:0]  wd = 8'h00;
  logic [2:0]  alen = 3'h0;
  logic [7:0]  rdata, cs_n, cs_oe, m_cs, m_len, v;
  logic        busy, done, rd_n, wr_n, b16, lan, mpage, boot, m_vld, pin;
  logic [23:0] maddr;
  logic [23:0] q_rd[$], q_acc[$];
  int          error_cnt = 0, checks_done = 0, seed = 9341, i;
  logic [7:0]  offs[13] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5,
    8'hC6, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hB0, 8'hC7};
  logic [7:0]  rv[13] = '{8'h80, 8'hFF, 8'h27, 8'h77, 8'h71, 8'h22,
    8'h00, 8'h80, 8'h80, 8'hA3, 8'hA3, 8'h00, 8'h00};
  logic [7:0]  msk[13] = '{8'hFF, 8'hFF, 8'h77, 8'h77, 8'h77, 8'h77,
    8'hFF, 8'hFF, 8'hFF, 8'hF3, 8'hF3, 8'hFF, 8'h00};
  eab_acc_t    nt[14] = '{
    '{24'hE00010, 1'b1, 3'h0, 8'h05}, '{24'hC00000, 1'b0, 3'h0, 8'h0A},
    '{24'h400000, 1'b1, 3'h0, 8'h05}, '{24'h600000, 1'b0, 3'h0, 8'h0B},
    '{24'h800000, 1'b1, 3'h0, 8'h0B}, '{24'hA00004, 1'b0, 3'h0, 8'h0B},
    '{24'h000000, 1'b1, 3'h3, 8'h0E}, '{24'h000000, 1'b1, 3'h7, 8'h0E},
    '{24'h200000, 1'b1, 3'h3, 8'h0E}, '{24'h200000, 1'b0, 3'h0, 8'h05},
    '{24'hF80000, 1'b1, 3'h0, 8'h05}, '{24'hFF4000, 1'b1, 3'h0, 8'h05},
    '{24'hFF4000, 1'b1, 3'h0, 8'h00}, '{24'hFFFC10, 1'b0, 3'h0, 8'h00}};
  eab_acc_t    bt[5] = '{
    '{24'h000010, 1'b1, 3'h3, 8'h18}, '{24'h1A0010, 1'b1, 3'h0, 8'h06},
    '{24'hE80010, 1'b1, 3'h0, 8'h05}, '{24'h200000, 1'b1, 3'h0, 8'h05},
    '{24'h200000, 1'b0, 3'h0, 8'h05}};

  always #4 clk = ~clk;

  eab_ctrl eab_ctrl_inst (
    .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_REG_ADDR(ra),
    .I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .I_BOOT_STRAP(strap), .I_PAGE_PIN(pin), .I_INT_RAM_EN(iram),
    .I_ACC_REQ(req), .I_ACC_ADDR(aa), .I_ACC_RD(ard), .I_ACC_LEN(alen),
    .O_ACC_BUSY(busy), .O_ACC_DONE(done), .O_CS_N(cs_n), .O_CS_OE(cs_oe),
    .O_RD_N(rd_n), .O_WR_N(wr_n), .O_MEM_ADDR(maddr), .O_BUS16(b16),
    .O_LAN_SEL(lan), .O_MAIN_PAGE(mpage), .O_BOOT_MODE(boot));

  eab_mem_model eab_mem_model_inst (
    .i_clk(clk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_page_sel(pg), .o_page_pin(pin), .o_vld(m_vld),
    .o_cs(m_cs), .o_len(m_len));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic do_reset(input logic b);
    @(posedge clk);
    strap  <= b;
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : do_reset

  task automatic wreg(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [23:0] a, input logic [7:0] e);
    q_rd.push_back({16'h0000, e});
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg

  task automatic reg_vals;
    for (int j = 0; j < 13; j++) rreg(24'hFFFE00 | offs[j], rv[j]);
    repeat (2) @(posedge clk);
  endtask : reg_vals

  function automatic logic [23:0] xl(input logic [23:0] a);
    if (a[23:18] == 6'h3E) return {20'h00000, a[3:0]};
    if (a[23:20] == 4'hE || (strap && a[23:21] == 3'h0))
      return {5'h00, a[18:0]};
    return a;
  endfunction : xl

  task automatic acc(input eab_acc_t t);
    int k;
    if (t.s != 8'h00) q_acc.push_back({~(8'h01 << t.a[23:21]), t.s});
    @(posedge clk);
    aa   <= t.a;
    ard  <= t.r;
    alen <= t.n;
    req  <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 60);
    if (t.s == 8'h00) chk({busy, cs_n, k < 3}, 32'h1FF);
    else begin
      chk({lan, maddr}, {t.a[23:18] == 6'h3E, xl(t.a)});
      chk(mpage, strap ? pg : t.a[23:21] == 3'h1);
    end
  endtask : acc

  // ----------------------------------------------------------------
  // result watcher, watchdog and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) chk(rdata, q_rd.pop_front());
    if (m_vld) chk({m_cs, m_len}, q_acc.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  initial begin
    do_reset(1'b0);
    chk({boot, cs_oe}, 9'h000);
    reg_vals();
    $display("normal reset values done");
    for (i = 0; i < 13; i++) begin
      v = 8'($random(seed));
      wreg(24'hFFFE00 | offs[i], v);
      rreg(24'hFFFE00 | offs[i], v & msk[i]);
      wreg(24'hFFFE00 | offs[i], rv[i]);
    end
    wreg(24'hFFFEB0, v);
    @(negedge clk);
    chk(cs_oe, v);
    wreg(24'hFFFEB0, 8'hFF);
    $display("register access done");
    nt[10].a = 24'hF80000 | (24'($random(seed)) & 24'h03FFFF);
    for (i = 0; i < 14; i++) begin
      @(posedge clk);
      iram <= (nt[i].s == 8'h00);
      acc(nt[i]);
    end
    $display("normal mode accesses done");
    do_reset(1'b1);
    chk(boot, 1'b1);
    rv[0] = 8'h81;
    rv[5] = 8'h23;
    rv[9] = 8'hD3;
    reg_vals();
    $display("boot reset values done");
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      pg <= (i == 4);
      repeat (4) @(posedge clk);
      acc(bt[i]);
    end
    repeat (4) @(posedge clk);
    $display("boot mode accesses done");
    test_done();
  end
endmodule : tb
